/* File: src/rps_pkg.sv */
/*
 * Constants, state encoding and carrier structs for the rail power sequencer.
 * Assumes a single 10 MHz clock; all times are turned into cycle counts here.
 */
package rps_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HZ_PER_KHZ = 1000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;

    // Power-up times in ms, as specified
    localparam int unsigned EN_DLY_MS = 11;
    localparam int unsigned MON_MS = 10;
    localparam int unsigned RST_DLY_MS = 10;

    // Power-down and filter times in us; each sits inside its allowed window
    localparam int unsigned REQ_FLT_US = 100;
    localparam int unsigned VM_FLT_US = 60;
    localparam int unsigned PARK_US = 100;
    localparam int unsigned RST_ASSERT_US = 200;

    localparam int unsigned EN_DLY_CYC_DEF = EN_DLY_MS * (CLK_HZ / HZ_PER_KHZ);
    localparam int unsigned MON_CYC_DEF = MON_MS * (CLK_HZ / HZ_PER_KHZ);
    localparam int unsigned RST_DLY_CYC_DEF = RST_DLY_MS * (CLK_HZ / HZ_PER_KHZ);
    localparam int unsigned REQ_FLT_CYC = REQ_FLT_US * (CLK_HZ / HZ_PER_MHZ);
    localparam int unsigned VM_FLT_CYC = VM_FLT_US * (CLK_HZ / HZ_PER_MHZ);
    localparam int unsigned PARK_CYC = PARK_US * (CLK_HZ / HZ_PER_MHZ);
    localparam int unsigned RST_ASSERT_CYC = RST_ASSERT_US * (CLK_HZ / HZ_PER_MHZ);

    localparam int unsigned CNT_W = 17;
    localparam int unsigned FLT_W = 11;
    localparam int unsigned SYNC_W = 5;

    // Bit positions in the synchroniser word
    localparam int unsigned SY_REQ = 0;
    localparam int unsigned SY_VM = 1;
    localparam int unsigned SY_CORE = 2;
    localparam int unsigned SY_MID = 3;
    localparam int unsigned SY_IO = 4;

    typedef enum logic [3:0] {
        RPS_OFF = 4'h0,
        RPS_WAIT_CORE = 4'h1,
        RPS_CHK_CORE = 4'h2,
        RPS_CHK_MID = 4'h3,
        RPS_CHK_IO = 4'h4,
        RPS_WAIT_RST = 4'h5,
        RPS_RUN = 4'h6,
        RPS_FAULT = 4'h7,
        RPS_PARK = 4'h8,
        RPS_DISCH = 4'h9,
        RPS_SHUT = 4'hA
    } rps_state_e;

    typedef struct packed {
        logic coreEn;
        logic midEn;
        logic ioEn;
        logic resetN;
        logic parkN;
        logic discharge;
    } rps_out_s;

    typedef struct packed {
        rps_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic reqFilt;
        logic [FLT_W-1:0] reqCnt;
        logic vmOk;
        logic [FLT_W-1:0] vmCnt;
        rps_out_s out;
    } rps_regs_s;

    localparam rps_out_s OUT_RESET = '{coreEn: 1'b0, midEn: 1'b0, ioEn: 1'b0,
                                       resetN: 1'b0, parkN: 1'b1, discharge: 1'b0};

endpackage : rps_pkg

/* File: src/rps_rail_power_sequencer.sv */
/*
 * Rail power sequencer: enables core, mid and I/O rails in turn, checks each
 * monitor, releases system reset, and parks, discharges and resets on power loss.
 * Assumes monitor and sense inputs are asynchronous pins; rail monitors and the
 * main supply sense are logic levels, high when the supply is above threshold.
 */
// Behaviour
// - Core enable 11 ms after request rise
// - Check core monitor 10 ms after enable
// - Check mid monitor 10 ms after enable
// - Check I/O monitor 10 ms after enable
// - Release reset 10 ms after I/O check
// - Failed check holds reset; host restarts
// - Power-down on supply loss or request drop
// - Park within 1 ms of request fall
// - Discharge within 280 us of park
// - Reset asserted within 500 us of discharge
// - Filter short main supply dips
`timescale 1ns/100ps
module rps_rail_power_sequencer
    import rps_pkg::*;
#(
    parameter int unsigned EN_DLY_CYC = EN_DLY_CYC_DEF,
    parameter int unsigned MON_CYC = MON_CYC_DEF,
    parameter int unsigned RST_DLY_CYC = RST_DLY_CYC_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic powerRequestIn,
    input wire logic mainSupplySense,
    input wire logic coreRailGood,
    input wire logic midRailGood,
    input wire logic ioRailGood,
    output logic coreRailEnable,
    output logic midRailEnable,
    output logic ioRailEnable,
    output logic systemResetN,
    output logic mirrorParkN,
    output logic mirrorOffsetDischarge
);

    // Request filtering is part of the 11 ms delay, so only the rest is waited
    localparam int unsigned EN_WAIT_CYC = EN_DLY_CYC - REQ_FLT_CYC;

    rps_regs_s cur_reg;
    rps_regs_s cur_next;

    function automatic logic rps_hit(input logic [CNT_W-1:0] c, input int unsigned lim);
        return c == CNT_W'(lim - 1);
    endfunction : rps_hit

    function automatic logic rps_fhit(input logic [FLT_W-1:0] c, input int unsigned lim);
        return c == FLT_W'(lim - 1);
    endfunction : rps_fhit

    function automatic rps_out_s rps_decode(input rps_state_e s);
        rps_out_s o;
        o = OUT_RESET;
        case (s)
            RPS_OFF, RPS_WAIT_CORE: begin
                o = OUT_RESET;
            end
            RPS_CHK_CORE: begin
                o.coreEn = 1'b1;
            end
            RPS_CHK_MID: begin
                o.coreEn = 1'b1;
                o.midEn = 1'b1;
            end
            RPS_CHK_IO, RPS_WAIT_RST, RPS_FAULT: begin
                o.coreEn = 1'b1;
                o.midEn = 1'b1;
                o.ioEn = 1'b1;
            end
            RPS_RUN: begin
                o.coreEn = 1'b1;
                o.midEn = 1'b1;
                o.ioEn = 1'b1;
                o.resetN = 1'b1;
            end
            RPS_PARK: begin
                // Reset stays as it was through park and discharge, until RPS_SHUT
                o.coreEn = 1'b1;
                o.midEn = 1'b1;
                o.ioEn = 1'b1;
                o.resetN = 1'b1;
                o.parkN = 1'b0;
            end
            RPS_DISCH: begin
                o.coreEn = 1'b1;
                o.midEn = 1'b1;
                o.ioEn = 1'b1;
                o.resetN = 1'b1;
                o.parkN = 1'b0;
                o.discharge = 1'b1;
            end
            RPS_SHUT: begin
                o.parkN = 1'b0;
                o.discharge = 1'b1;
            end
            default: begin
                o = OUT_RESET;
            end
        endcase
        return o;
    endfunction : rps_decode

    logic powered;
    logic reqIn;
    logic vmIn;

    always_comb begin
        cur_next = cur_reg;
        cur_next.sync1 = {ioRailGood, midRailGood, coreRailGood, mainSupplySense,
                          powerRequestIn};
        cur_next.sync2 = cur_reg.sync1;
        reqIn = cur_reg.sync2[SY_REQ];
        vmIn = cur_reg.sync2[SY_VM];
        powered = (cur_reg.st == RPS_CHK_CORE) || (cur_reg.st == RPS_CHK_MID) ||
                  (cur_reg.st == RPS_CHK_IO) || (cur_reg.st == RPS_WAIT_RST) ||
                  (cur_reg.st == RPS_RUN) || (cur_reg.st == RPS_FAULT);

        // Request must hold a new level for the whole filter time
        cur_next.reqCnt = '0;
        if (reqIn != cur_reg.reqFilt) begin
            cur_next.reqCnt = cur_reg.reqCnt + 1'b1;
            if (rps_fhit(cur_reg.reqCnt, REQ_FLT_CYC)) begin
                cur_next.reqFilt = reqIn;
                cur_next.reqCnt = '0;
            end
        end

        // Dips shorter than the filter time are not treated as power loss
        cur_next.vmCnt = '0;
        if (vmIn != cur_reg.vmOk) begin
            cur_next.vmCnt = cur_reg.vmCnt + 1'b1;
            if (rps_fhit(cur_reg.vmCnt, VM_FLT_CYC)) begin
                cur_next.vmOk = vmIn;
                cur_next.vmCnt = '0;
            end
        end

        cur_next.cnt = cur_reg.cnt + 1'b1;
        case (cur_reg.st)
            RPS_OFF: begin
                cur_next.cnt = '0;
                if (cur_reg.reqFilt && cur_reg.vmOk) begin
                    cur_next.st = RPS_WAIT_CORE;
                end
            end
            RPS_WAIT_CORE: begin
                if (!cur_reg.reqFilt || !cur_reg.vmOk) begin
                    cur_next.st = RPS_OFF;
                    cur_next.cnt = '0;
                end else if (rps_hit(cur_reg.cnt, EN_WAIT_CYC)) begin
                    cur_next.st = RPS_CHK_CORE;
                    cur_next.cnt = '0;
                end
            end
            RPS_CHK_CORE: begin
                // Full wait even if the rail is good early
                if (rps_hit(cur_reg.cnt, MON_CYC)) begin
                    cur_next.st = cur_reg.sync2[SY_CORE] ? RPS_CHK_MID : RPS_FAULT;
                    cur_next.cnt = '0;
                end
            end
            RPS_CHK_MID: begin
                if (rps_hit(cur_reg.cnt, MON_CYC)) begin
                    cur_next.st = cur_reg.sync2[SY_MID] ? RPS_CHK_IO : RPS_FAULT;
                    cur_next.cnt = '0;
                end
            end
            RPS_CHK_IO: begin
                if (rps_hit(cur_reg.cnt, MON_CYC)) begin
                    cur_next.st = cur_reg.sync2[SY_IO] ? RPS_WAIT_RST : RPS_FAULT;
                    cur_next.cnt = '0;
                end
            end
            RPS_WAIT_RST: begin
                if (rps_hit(cur_reg.cnt, RST_DLY_CYC)) begin
                    cur_next.st = RPS_RUN;
                    cur_next.cnt = '0;
                end
            end
            RPS_RUN, RPS_FAULT: begin
                // A fault is left only through power-down, so the host restarts
                cur_next.cnt = '0;
            end
            RPS_PARK: begin
                if (rps_hit(cur_reg.cnt, PARK_CYC)) begin
                    cur_next.st = RPS_DISCH;
                    cur_next.cnt = '0;
                end
            end
            RPS_DISCH: begin
                if (rps_hit(cur_reg.cnt, RST_ASSERT_CYC)) begin
                    cur_next.st = RPS_SHUT;
                    cur_next.cnt = '0;
                end
            end
            RPS_SHUT: begin
                // Restart needs the request to go low first
                cur_next.cnt = '0;
                if (!cur_reg.reqFilt) begin
                    cur_next.st = RPS_OFF;
                end
            end
            default: begin
                cur_next.st = RPS_OFF;
                cur_next.cnt = '0;
            end
        endcase

        if (powered && (!cur_reg.vmOk || !cur_reg.reqFilt)) begin
            cur_next.st = RPS_PARK;
            cur_next.cnt = '0;
        end

        cur_next.out = rps_decode(cur_next.st);
        // Enables and reset only hold here, so a failed check never raises them
        if ((cur_next.st == RPS_FAULT) || (cur_next.st == RPS_PARK) ||
            (cur_next.st == RPS_DISCH)) begin
            cur_next.out.coreEn = cur_reg.out.coreEn;
            cur_next.out.midEn = cur_reg.out.midEn;
            cur_next.out.ioEn = cur_reg.out.ioEn;
            cur_next.out.resetN = cur_reg.out.resetN;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_reg.st <= RPS_OFF;
            cur_reg.cnt <= '0;
            cur_reg.sync1 <= '0;
            cur_reg.sync2 <= '0;
            cur_reg.reqFilt <= 1'b0;
            cur_reg.reqCnt <= '0;
            cur_reg.vmOk <= 1'b0;
            cur_reg.vmCnt <= '0;
            cur_reg.out <= OUT_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign coreRailEnable = cur_reg.out.coreEn;
    assign midRailEnable = cur_reg.out.midEn;
    assign ioRailEnable = cur_reg.out.ioEn;
    assign systemResetN = cur_reg.out.resetN;
    assign mirrorParkN = cur_reg.out.parkN;
    assign mirrorOffsetDischarge = cur_reg.out.discharge;

    localparam int PARK_LIM = PARK_CYC;
    localparam int RST_LIM = RST_ASSERT_CYC;

    logic [CNT_W-1:0] dischAge;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dischAge <= '0;
        end else if (mirrorOffsetDischarge && systemResetN) begin
            dischAge <= dischAge + 1'b1;
        end else begin
            dischAge <= '0;
        end
    end

    sequence s_check_done;
        rps_hit(cur_reg.cnt, MON_CYC);
    endsequence

    sequence s_park_then_disch;
        !mirrorParkN [*1] ##[1:PARK_LIM] mirrorOffsetDischarge;
    endsequence

    a_core_enable_delay: assert property (@(posedge mclk) disable iff (rst)
        $rose(coreRailEnable) |-> $past(cur_reg.st) == RPS_WAIT_CORE &&
        $past(cur_reg.cnt) == CNT_W'(EN_WAIT_CYC - 1))
        else $error("core enable not at its delay");

    a_mid_after_check: assert property (@(posedge mclk) disable iff (rst)
        (s_check_done and (cur_reg.st == RPS_CHK_CORE && cur_reg.sync2[SY_CORE] && powered &&
        cur_reg.vmOk && cur_reg.reqFilt)) |=> $rose(midRailEnable))
        else $error("mid enable missing after good core check");

    a_io_after_check: assert property (@(posedge mclk) disable iff (rst)
        $rose(ioRailEnable) |-> $past(cur_reg.st) == RPS_CHK_MID &&
        $past(cur_reg.sync2[SY_MID]) && $past(cur_reg.cnt) == CNT_W'(MON_CYC - 1))
        else $error("I/O enable without passed mid check");

    a_enable_order: assert property (@(posedge mclk) disable iff (rst)
        (ioRailEnable |-> midRailEnable) and (midRailEnable |-> coreRailEnable))
        else $error("rail enables out of order");

    a_reset_release: assert property (@(posedge mclk) disable iff (rst)
        $rose(systemResetN) |-> $past(cur_reg.st) == RPS_WAIT_RST &&
        $past(cur_reg.cnt) == CNT_W'(RST_DLY_CYC - 1) && ioRailEnable)
        else $error("reset released without delay after I/O check");

    a_fault_holds_reset: assert property (@(posedge mclk) disable iff (rst)
        (s_check_done and (cur_reg.st == RPS_CHK_IO && !cur_reg.sync2[SY_IO])) |=>
        !systemResetN [*2])
        else $error("reset released after failed check");

    a_loss_parks: assert property (@(posedge mclk) disable iff (rst)
        powered && (!cur_reg.vmOk || !cur_reg.reqFilt) |=> !mirrorParkN)
        else $error("power-down not started");

    a_vm_trip_park: assert property (@(posedge mclk) disable iff (rst)
        $fell(cur_reg.vmOk) && powered |=> $fell(mirrorParkN))
        else $error("park not driven after supply trip");

    a_park_disch: assert property (@(posedge mclk) disable iff (rst)
        $fell(mirrorParkN) |-> s_park_then_disch)
        else $error("discharge late after park");

    a_reset_bound: assert property (@(posedge mclk) disable iff (rst)
        dischAge <= CNT_W'(RST_LIM))
        else $error("reset not asserted in time after discharge");

    a_glitch_window: assert property (@(posedge mclk) disable iff (rst)
        $fell(cur_reg.vmOk) |-> $past(cur_reg.vmCnt) == FLT_W'(VM_FLT_CYC - 1))
        else $error("supply trip accepted without full filter");

    a_off_safe: assert property (@(posedge mclk) disable iff (rst)
        cur_reg.st == RPS_OFF |-> !coreRailEnable && !midRailEnable &&
        !ioRailEnable && !systemResetN && mirrorParkN)
        else $error("off state outputs not safe");

endmodule : rps_rail_power_sequencer

/* File: tb/rps_rail_model.sv */
/*
 * Behavioural model of the three external regulators behind the rail enables.
 * Assumes one clock shared with the sequencer; bit 0 core, 1 mid, 2 I/O.
 */
`timescale 1ns/100ps
module rps_rail_model
    import rps_pkg::*;
#(
    parameter int unsigned RISE_CYC = 20
) (
    input wire logic mclk,
    input wire logic [2:0] railEnable,
    input wire logic [2:0] railFail,
    output logic [2:0] railGood
);
    int unsigned upCnt [3] = '{0, 0, 0};

    // Ramp is shorter than the monitor interval, so a good rail is valid by its check
    always @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            if (!railEnable[i]) begin
                upCnt[i] <= 0;
            end else if (upCnt[i] < RISE_CYC) begin
                upCnt[i] <= upCnt[i] + 1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            railGood[i] = (upCnt[i] >= RISE_CYC) && !railFail[i];
        end
    end
endmodule : rps_rail_model

/* File: tb/rail_power_sequencer_tb.sv */
/*
 * Self-checking bench for the rail power sequencer, with shortened power-up counts.
 * Assumes the regulator model answers the enables; the bench plays host and supply.
 */
`timescale 1ns/100ps
module rail_power_sequencer_tb;
    import rps_pkg::*;
    localparam int EN_CYC = 1100;
    localparam int MON = 50;
    localparam int RDLY = 50;
    typedef struct {int sig; logic val; int lo; int hi; string name;} rps_row_s;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic powerRequestIn = 1'b0;
    logic mainSupplySense = 1'b1;
    logic [2:0] railFail = 3'b000;
    logic [2:0] railGood;
    logic coreRailEnable, midRailEnable, ioRailEnable;
    logic systemResetN, mirrorParkN, mirrorOffsetDischarge;
    rps_out_s outs;
    int nErrors = 0;
    int totalChecks = 0;
    // Intervals are counted from the previous row's event, or from the last drive for the first row of a run
    rps_row_s rows [10] = '{
        '{0, 1'b1, EN_CYC - 5, EN_CYC + 10, "core enable"},
        '{1, 1'b1, MON, MON + 2, "mid enable"},
        '{2, 1'b1, MON, MON + 2, "io enable"},
        '{3, 1'b1, MON + RDLY, MON + RDLY + 3, "reset release"},
        '{4, 1'b0, 1, 10000, "park after request drop"},
        '{5, 1'b1, 1, 2800, "discharge"},
        '{3, 1'b0, 1, 5000, "reset assert"},
        '{4, 1'b0, 520, 1200, "park after supply trip"},
        '{5, 1'b1, 1, 2800, "discharge"},
        '{3, 1'b0, 1, 5000, "reset assert"}
    };

    always #50 mclk = ~mclk;
    assign outs = '{coreEn: coreRailEnable, midEn: midRailEnable, ioEn: ioRailEnable,
                    resetN: systemResetN, parkN: mirrorParkN, discharge: mirrorOffsetDischarge};

    rps_rail_power_sequencer #(.EN_DLY_CYC(EN_CYC), .MON_CYC(MON), .RST_DLY_CYC(RDLY)) uut (
        .mclk(mclk),
        .rst(rst),
        .powerRequestIn(powerRequestIn),
        .mainSupplySense(mainSupplySense),
        .coreRailGood(railGood[0]),
        .midRailGood(railGood[1]),
        .ioRailGood(railGood[2]),
        .coreRailEnable(coreRailEnable),
        .midRailEnable(midRailEnable),
        .ioRailEnable(ioRailEnable),
        .systemResetN(systemResetN),
        .mirrorParkN(mirrorParkN),
        .mirrorOffsetDischarge(mirrorOffsetDischarge)
    );

    rps_rail_model #(.RISE_CYC(20)) railModel (
        .mclk(mclk),
        .railEnable({ioRailEnable, midRailEnable, coreRailEnable}),
        .railFail(railFail),
        .railGood(railGood)
    );

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    function automatic logic pick(input int s);
        case (s)
            0: return coreRailEnable;
            1: return midRailEnable;
            2: return ioRailEnable;
            3: return systemResetN;
            4: return mirrorParkN;
            default: return mirrorOffsetDischarge;
        endcase
    endfunction : pick

    task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
            nErrors++;
        end
    endtask : chk

    // Bounded wait per row; a row that runs past its bound ends the run
    task automatic run_rows(input int first, input int last);
        int n;
        for (int r = first; r <= last; r++) begin
            n = 0;
            while (pick(rows[r].sig) !== rows[r].val && n <= rows[r].hi) begin
                @(negedge mclk);
                n++;
            end
            totalChecks++;
            if (n < rows[r].lo || n > rows[r].hi) begin
                $display("wrong value %s: expected %0d..%0d cycles, seen %0d",
                         rows[r].name, rows[r].lo, rows[r].hi, n);
                nErrors++;
                if (n > rows[r].hi) end_sim();
            end
        end
    endtask : run_rows

    task automatic drive(input logic req, input logic sense, input int gap);
        @(posedge mclk);
        powerRequestIn <= req;
        mainSupplySense <= sense;
        @(negedge mclk);
        repeat (gap) @(negedge mclk);
    endtask : drive

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("outputs after reset", OUT_RESET, outs);
        $display("Test reset done");
        drive(1'b1, 1'b1, 0);
        run_rows(0, 3);
        // Dip shorter than the lower glitch bound must not start power-down
        drive(1'b1, 1'b0, 150);
        drive(1'b1, 1'b1, 1500);
        chk("state after short dip", 6'h3E, outs);
        drive(1'b0, 1'b1, 0);
        run_rows(4, 6);
        chk("enables off at reset", 6'h01, outs);
        repeat (1200) @(negedge mclk);
        chk("idle after power-down", OUT_RESET, outs);
        $display("Test request power-down done");
        drive(1'b1, 1'b1, 0);
        run_rows(0, 3);
        drive(1'b1, 1'b0, 0);
        run_rows(7, 9);
        drive(1'b0, 1'b1, 1200);
        chk("idle after supply loss", OUT_RESET, outs);
        $display("Test supply power-down done");
        railFail <= 3'b100;
        drive(1'b1, 1'b1, 0);
        run_rows(0, 2);
        repeat (MON + RDLY + 200) @(negedge mclk);
        chk("reset held on failed check", 1'b0, systemResetN);
        chk("enables held on fault", 6'h3A, outs);
        // Request filter, park, discharge and shut take about 4000 cycles before the idle state
        drive(1'b0, 1'b1, 4200);
        chk("idle after fault", OUT_RESET, outs);
        railFail <= 3'b000;
        drive(1'b1, 1'b1, 0);
        run_rows(0, 3);
        $display("Test failed check and restart done");
        end_sim();
    end
endmodule : rail_power_sequencer_tb
